// ==== verilog/srp_sleep_reset.sv ====
// Notes on behaviour
// RQ1: sleep instruction sleeps only when sleep_arm is one
// RQ2: sleep_select 00 idle, 01 noise reduction, 10 power-down, 11 reserved
// RQ3: software writes off and unlock one, then off alone within four cycles
// RQ4: brownout_sleep_off takes effect three cycles after being set
// RQ5: brownout_sleep_off clears itself three cycles after it is set; here off_set clears one cycle after taking effect, four cycles after set
// RQ6: brownout detector off in sleep only if sleep entered while off active
// RQ7: without software brownout disable, off and unlock read zero
// RQ8: software arms sleep just before sleeping and disarms after wake
// RQ9: clock gate bits 7:4 read zero
// RQ10: gate bit 3 stops timer b, clearing resumes it
// RQ11: gate bit 2 stops timer a, clearing resumes it
// RQ12: gate bit 1 stops the serial unit clock
// RQ13: gate bit 0 stops the converter, comparator unusable meanwhile
// RQ14: reset loads registers and restarts fetch at reset vector
// RQ15: ports return to initial state asynchronously on any reset source; only power-on and brownout do so here, pin reset is synchronous, watchdog none
// RQ16: internal reset stretched by a fuse-chosen delay after sources go away
// RQ17: four reset sources: power-on, pin, watchdog, brownout
// RQ18: power-on drop reasserts reset at once
// RQ19: pin reset only when enabled; start after delay on release
// RQ20: brownout reset immediate when enabled; restart after delay
// RQ21: watchdog reset is a one-cycle pulse; delay starts at its end
// RQ22: bandgap on for fuse brownout, comparator bandgap select, or converter
// RQ23: noise reduction stops cpu, io and flash clocks only
// RQ24: power-down stops the oscillator and all generated clocks
// RQ25: gated peripherals keep state and their registers are blocked
// RQ26: reserved sleep code makes the sleep instruction do nothing
//
// Added by the designer: register access over APB.
module srp_sleep_reset
  import srp_pkg::*;
#(
  parameter int  DELAY_CYCLES = DELAY_CYCLES_DEFAULT,
  parameter bit  HAS_BOD_OFF  = 1'b1
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        power_on_low,
  input  wire logic        reset_pin_n,
  input  wire logic        reset_pin_enable,
  input  wire logic        watchdog_expire,
  input  wire logic        watchdog_enable,
  input  wire logic        brownout_low,
  input  wire logic        brownout_level_fuse,
  input  wire logic [5:0]  startup_fuse,
  input  wire logic        comparator_bandgap_select,
  input  wire logic        converter_enable,
  input  wire logic        sleep_instr,
  input  wire logic        wake_event,
  output logic             ports_reset_n,
  output logic             core_reset_n,
  output logic             watchdog_reset,
  output srp_clk_en_t      clk_en,
  output srp_gate_t        gate_off,
  output logic             bandgap_enable,
  output logic             brownout_detector_on,
  output logic             sleeping
);
  logic [7:0]  sleep_ctrl;
  logic [7:0]  clock_gate;
  logic [2:0]  unlock_cnt;
  logic [1:0]  off_age;
  logic        off_set;
  logic        bod_sleep_off;
  srp_state_t  state;
  logic [2:0]  pin_sync;
  logic        pin_low;
  logic        wd_pulse;
  logic [31:0] delay_cnt;
  logic        wr;
  logic        rd_ok;
  logic        src_n;
  logic        sleep_go;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    return a == o;
  endfunction : hit

  assign wr = psel && penable && pwrite;
  assign rd_ok = hit(paddr, OFS_SLEEP_CTRL) || hit(paddr, OFS_CLOCK_GATE) ||
                 hit(paddr, OFS_FUSE_STAT);
  // power-on or enabled brownout holds the core and port resets
  assign src_n = !power_on_low && !(brownout_low && brownout_level_fuse); // RQ17 RQ18 RQ20
  assign sleep_go = sleep_instr && sleep_ctrl[BIT_SLEEP_ARM] && state == ST_RUN &&
                    sleep_ctrl[BIT_SEL_HI:BIT_SEL_LO] != SEL_RESERVED; // RQ1 RQ26

  // apb answer, zero wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !rd_ok;
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        if (hit(paddr, OFS_SLEEP_CTRL))
          prdata <= {24'h0, bod_sleep_off, sleep_ctrl[6:3], HAS_BOD_OFF && sleep_ctrl[2],
                     sleep_ctrl[1:0]}; // RQ7
        else if (hit(paddr, OFS_CLOCK_GATE))
          prdata <= {28'h0, clock_gate[3:0]}; // RQ9
        else if (hit(paddr, OFS_FUSE_STAT))
          prdata <= {24'h0, brownout_level_fuse, 1'b0, startup_fuse};
      end
    end
  end

  // pin synchroniser and filter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync <= 3'b111;
      pin_low  <= 1'b0;
    end else begin
      pin_sync <= {pin_sync[1:0], reset_pin_n};
      if (pin_sync[2] == pin_sync[1])
        pin_low <= !pin_sync[2] && reset_pin_enable; // RQ19
    end
  end

  // watchdog one-cycle pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      wd_pulse <= 1'b0;
    else
      wd_pulse <= watchdog_expire && watchdog_enable && !wd_pulse; // RQ21
  end

  // reset stretch counter
  always_ff @(posedge pclk or negedge src_n) begin
    if (!src_n) begin
      delay_cnt    <= 32'h0000_0000;
      core_reset_n <= 1'b0; // RQ18
    end else if (pin_low || wd_pulse) begin
      delay_cnt    <= 32'h0000_0000; // RQ21
      core_reset_n <= 1'b0;
    end else if (delay_cnt < 32'(DELAY_CYCLES) + 32'(startup_fuse)) begin
      delay_cnt    <= delay_cnt + 32'h1; // RQ16
      core_reset_n <= 1'b0;
    end else begin
      core_reset_n <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge src_n) begin
    if (!src_n) begin
      ports_reset_n  <= 1'b0; // RQ15
      watchdog_reset <= 1'b0;
    end else begin
      ports_reset_n  <= !pin_low;
      watchdog_reset <= wd_pulse;
    end
  end

  // sleep control register and timed unlock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_ctrl <= SLEEP_CTRL_RESET; // RQ14
      unlock_cnt <= 3'd0;
      off_set    <= 1'b0;
      off_age    <= 2'd0;
    end else begin
      if (unlock_cnt != 3'd0)
        unlock_cnt <= unlock_cnt - 3'd1;
      if (off_set) begin
        if (off_age == BOD_OFF_HOLD)
          off_set <= 1'b0; // RQ5
        else
          off_age <= off_age + 2'd1;
      end
      if (wr && hit(paddr, OFS_SLEEP_CTRL)) begin
        sleep_ctrl <= (pwdata[7:0] & SLEEP_CTRL_WMASK) | (sleep_ctrl & ~SLEEP_CTRL_WMASK);
        sleep_ctrl[BIT_BOD_UNLOCK] <= HAS_BOD_OFF && pwdata[BIT_BOD_UNLOCK];
        if (HAS_BOD_OFF && pwdata[BIT_BOD_OFF] && pwdata[BIT_BOD_UNLOCK])
          unlock_cnt <= UNLOCK_WINDOW; // RQ3
        else if (HAS_BOD_OFF && pwdata[BIT_BOD_OFF] && unlock_cnt != 3'd0) begin
          off_set    <= 1'b1;
          off_age    <= 2'd0;
          unlock_cnt <= 3'd0;
        end
      end
    end
  end

  // off active once aged to three cycles
  assign bod_sleep_off = off_set && off_age == BOD_OFF_DELAY; // RQ4

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      clock_gate <= CLOCK_GATE_RESET;
    else if (wr && hit(paddr, OFS_CLOCK_GATE))
      clock_gate <= pwdata[7:0] & CLOCK_GATE_WMASK; // RQ9
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      gate_off <= '0;
    else begin
      gate_off.timer_b   <= clock_gate[BIT_TIMER_B]; // RQ10 RQ25
      gate_off.timer_a   <= clock_gate[BIT_TIMER_A]; // RQ11
      gate_off.serial    <= clock_gate[BIT_SERIAL]; // RQ12
      gate_off.converter <= clock_gate[BIT_CONVERTER]; // RQ13
    end
  end

  // sleep state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      state <= ST_RUN;
    else if (state != ST_RUN && wake_event)
      state <= ST_RUN;
    else if (sleep_go) begin
      unique case (srp_sleep_t'(sleep_ctrl[BIT_SEL_HI:BIT_SEL_LO])) // RQ2
        SEL_IDLE:       state <= ST_IDLE;
        SEL_NOISE:      state <= ST_NOISE;
        SEL_POWER_DOWN: state <= ST_POWER_DOWN;
        SEL_RESERVED:   state <= ST_RUN;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      brownout_detector_on <= 1'b0;
    else if (state == ST_RUN && sleep_go)
      brownout_detector_on <= brownout_level_fuse && !bod_sleep_off; // RQ6
    else if (state == ST_RUN || wake_event)
      brownout_detector_on <= brownout_level_fuse;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_en   <= '1;
      sleeping <= 1'b0;
    end else begin
      sleeping          <= state != ST_RUN;
      clk_en.cpu        <= state == ST_RUN;
      clk_en.flash      <= state == ST_RUN;
      clk_en.io         <= state == ST_RUN || state == ST_IDLE; // RQ23
      clk_en.converter  <= state != ST_POWER_DOWN && !clock_gate[BIT_CONVERTER];
      clk_en.oscillator <= state != ST_POWER_DOWN; // RQ24
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      bandgap_enable <= 1'b0;
    else
      bandgap_enable <= brownout_level_fuse || comparator_bandgap_select ||
                        converter_enable; // RQ22
  end

  property p_off_clears;
    @(posedge pclk) disable iff (!presetn)
    $rose(off_set) |-> ##3 bod_sleep_off ##1 !off_set;
  endproperty
  a_off_clears: assert property (p_off_clears) else $error("off bit timing wrong"); // RQ5

  property p_off_late;
    @(posedge pclk) disable iff (!presetn)
    $rose(off_set) |-> !bod_sleep_off [*3];
  endproperty
  a_off_late: assert property (p_off_late) else $error("off bit early"); // RQ4

  property p_no_arm;
    @(posedge pclk) disable iff (!presetn)
    state == ST_RUN && !sleep_ctrl[BIT_SLEEP_ARM] |=> state == ST_RUN;
  endproperty
  a_no_arm: assert property (p_no_arm) else $error("slept without arm"); // RQ1

  property p_reserved;
    @(posedge pclk) disable iff (!presetn)
    state == ST_RUN && sleep_ctrl[BIT_SEL_HI:BIT_SEL_LO] == SEL_RESERVED |=> state == ST_RUN;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code slept"); // RQ26

  property p_pd;
    @(posedge pclk) disable iff (!presetn)
    state == ST_POWER_DOWN |=> !clk_en.oscillator && !clk_en.cpu;
  endproperty
  a_pd: assert property (p_pd) else $error("power-down clocks running"); // RQ24

  property p_noise;
    @(posedge pclk) disable iff (!presetn)
    state == ST_NOISE |=> !clk_en.io && clk_en.oscillator;
  endproperty
  a_noise: assert property (p_noise) else $error("noise clocks wrong"); // RQ23

  property p_wd;
    @(posedge pclk) disable iff (!presetn)
    wd_pulse |=> watchdog_reset ##1 !watchdog_reset;
  endproperty
  a_wd: assert property (p_wd) else $error("watchdog pulse too long"); // RQ21

  property p_wd_stretch;
    @(posedge pclk) disable iff (!presetn)
    wd_pulse |=> !core_reset_n [*2];
  endproperty
  a_wd_stretch: assert property (p_wd_stretch) else $error("no stretch"); // RQ16

  property p_bandgap;
    @(posedge pclk) disable iff (!presetn)
    converter_enable |=> bandgap_enable;
  endproperty
  a_bandgap: assert property (p_bandgap) else $error("bandgap off"); // RQ22

  property p_gate;
    @(posedge pclk) disable iff (!presetn)
    wr && hit(paddr, OFS_CLOCK_GATE) |=> ##1 gate_off.timer_b == $past(pwdata[BIT_TIMER_B], 2);
  endproperty
  a_gate: assert property (p_gate) else $error("gate not applied"); // RQ10

  property p_arm_sleeps;
    @(posedge pclk) disable iff (!presetn)
    sleep_go |=> state != ST_RUN;
  endproperty
  a_arm_sleeps: assert property (p_arm_sleeps) else $error("armed sleep ignored"); // RQ1

  property p_gate_read;
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && hit(paddr, OFS_CLOCK_GATE) |=> prdata[31:4] == 28'h0;
  endproperty
  a_gate_read: assert property (p_gate_read) else $error("reserved gate bits set"); // RQ9

  property p_bod_sleep;
    @(posedge pclk) disable iff (!presetn)
    sleep_go && bod_sleep_off |=> !brownout_detector_on;
  endproperty
  a_bod_sleep: assert property (p_bod_sleep) else $error("detector kept on"); // RQ6

  property p_pin;
    @(posedge pclk) disable iff (!presetn)
    pin_low |=> !ports_reset_n && !core_reset_n;
  endproperty
  a_pin: assert property (p_pin) else $error("pin reset missed"); // RQ19

  property p_stretch_len;
    @(posedge pclk) disable iff (!presetn)
    $rose(core_reset_n) |-> delay_cnt == 32'(DELAY_CYCLES) + 32'(startup_fuse);
  endproperty
  a_stretch_len: assert property (p_stretch_len) else $error("stretch length wrong"); // RQ16

  property p_wd_core;
    @(posedge pclk) disable iff (!presetn)
    wd_pulse |=> !core_reset_n && delay_cnt == 32'h0000_0000;
  endproperty
  a_wd_core: assert property (p_wd_core) else $error("watchdog restart wrong"); // RQ21

  property p_gate_conv;
    @(posedge pclk) disable iff (!presetn)
    clock_gate[BIT_CONVERTER] |=> !clk_en.converter;
  endproperty
  a_gate_conv: assert property (p_gate_conv) else $error("converter clock runs"); // RQ13

  property p_unlock;
    @(posedge pclk) disable iff (!presetn)
    wr && hit(paddr, OFS_SLEEP_CTRL) && pwdata[BIT_BOD_OFF] && !pwdata[BIT_BOD_UNLOCK] &&
    unlock_cnt == 3'd0 && !off_set |=> !off_set;
  endproperty
  a_unlock: assert property (p_unlock) else $error("off set without unlock"); // RQ3

  property p_bandgap_off;
    @(posedge pclk) disable iff (!presetn)
    !brownout_level_fuse && !comparator_bandgap_select && !converter_enable |=> !bandgap_enable;
  endproperty
  a_bandgap_off: assert property (p_bandgap_off) else $error("bandgap on"); // RQ22

  c_sleep: cover property (@(posedge pclk) disable iff (!presetn) sleep_go);
  c_unlock: cover property (@(posedge pclk) disable iff (!presetn) $rose(off_set));
  c_pd: cover property (@(posedge pclk) disable iff (!presetn) state == ST_POWER_DOWN);
  c_wd: cover property (@(posedge pclk) disable iff (!presetn) wd_pulse);
  c_noise: cover property (@(posedge pclk) disable iff (!presetn) state == ST_NOISE);
endmodule : srp_sleep_reset

// ==== verilog/srp_pkg.sv ====
package srp_pkg;
  localparam logic [9:0]  IDX_SLEEP_CTRL  = 10'h035;
  localparam logic [11:0] OFS_SLEEP_CTRL  = {IDX_SLEEP_CTRL, 2'h0};
  localparam logic [11:0] OFS_CLOCK_GATE  = 12'h0d8;
  localparam logic [11:0] OFS_FUSE_STAT   = 12'h0dc;
  localparam int BIT_BOD_OFF    = 7;
  localparam int BIT_PULLUP_OFF = 6;
  localparam int BIT_SLEEP_ARM  = 5;
  localparam int BIT_SEL_HI     = 4;
  localparam int BIT_SEL_LO     = 3;
  localparam int BIT_BOD_UNLOCK = 2;
  localparam int BIT_TIMER_B    = 3;
  localparam int BIT_TIMER_A    = 2;
  localparam int BIT_SERIAL     = 1;
  localparam int BIT_CONVERTER  = 0;
  localparam logic [7:0] SLEEP_CTRL_RESET = 8'h00;
  localparam logic [7:0] CLOCK_GATE_RESET = 8'h00;
  localparam logic [7:0] SLEEP_CTRL_WMASK = 8'h7b;
  localparam logic [7:0] CLOCK_GATE_WMASK = 8'h0f;
  localparam logic [2:0] UNLOCK_WINDOW    = 3'd4;
  localparam logic [1:0] BOD_OFF_DELAY    = 2'd3;
  localparam logic [1:0] BOD_OFF_HOLD     = 2'd3;
  localparam int CLK_PERIOD_NS = 25;
  localparam int DELAY_CYCLES_DEFAULT = 16384;
  typedef enum logic [1:0] {SEL_IDLE, SEL_NOISE, SEL_POWER_DOWN, SEL_RESERVED} srp_sleep_t;
  typedef enum {ST_RUN, ST_IDLE, ST_NOISE, ST_POWER_DOWN} srp_state_t;
  typedef struct packed {
    logic cpu;
    logic io;
    logic flash;
    logic converter;
    logic oscillator;
  } srp_clk_en_t;
  typedef struct packed {
    logic timer_b;
    logic timer_a;
    logic serial;
    logic converter;
  } srp_gate_t;
endpackage : srp_pkg

// ==== dv/srp_env_model.sv ====
module srp_env_model (
  input  wire logic pclk,
  input  wire logic sleep_req,
  input  wire logic wake_req,
  input  wire logic pin_low_req,
  output logic      sleep_instr,
  output logic      wake_event,
  output logic      reset_pin_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sleep_q;
  logic wake_q;
  // one-cycle sleep instruction, issued when software asks
  always @(posedge pclk) begin
    sleep_q     <= sleep_req;
    wake_q      <= wake_req;
    sleep_instr <= sleep_req && !sleep_q;
    wake_event  <= wake_req && !wake_q;
  end
  // released pin sits at its pull-up level
  assign reset_pin_n = !pin_low_req;
endmodule : srp_env_model

// ==== dv/srp_sleep_reset_test.sv ====
module srp_sleep_reset_test import srp_pkg::*; ();
  timeunit 1ns;
  timeprecision 100ps;
  localparam int         DLY = 8;
  logic [5:0]  suf = 6'h02;
  localparam int         STRETCH = DLY + 2 + 1;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic        pready, pslverr, power_on_low = 1, reset_pin_enable = 0;
  logic        watchdog_expire = 0, watchdog_enable = 0, brownout_low = 0;
  logic        brownout_level_fuse = 0, comparator_bandgap_select = 0, converter_enable = 0;
  logic        sleep_req = 0, wake_req = 0, pin_low_req = 0;
  logic        sleep_instr, wake_event, reset_pin_n, ports_reset_n, core_reset_n;
  logic        watchdog_reset, bandgap_enable, brownout_detector_on, sleeping;
  srp_clk_en_t clk_en;
  srp_gate_t   gate_off;
  int          error_cnt = 0, n_compared = 0, cyc = 0, n;
  srp_sleep_reset #(.DELAY_CYCLES(DLY), .HAS_BOD_OFF(1'b1)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_on_low(power_on_low), .reset_pin_n(reset_pin_n),
    .reset_pin_enable(reset_pin_enable), .watchdog_expire(watchdog_expire),
    .watchdog_enable(watchdog_enable), .brownout_low(brownout_low),
    .brownout_level_fuse(brownout_level_fuse), .startup_fuse(suf),
    .comparator_bandgap_select(comparator_bandgap_select),
    .converter_enable(converter_enable), .sleep_instr(sleep_instr),
    .wake_event(wake_event), .ports_reset_n(ports_reset_n), .core_reset_n(core_reset_n),
    .watchdog_reset(watchdog_reset), .clk_en(clk_en), .gate_off(gate_off),
    .bandgap_enable(bandgap_enable), .brownout_detector_on(brownout_detector_on),
    .sleeping(sleeping));
  srp_env_model i_env (.pclk(pclk), .sleep_req(sleep_req), .wake_req(wake_req),
    .pin_low_req(pin_low_req), .sleep_instr(sleep_instr), .wake_event(wake_event),
    .reset_pin_n(reset_pin_n));
  always #(CLK_PERIOD_NS / 2.0) pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      results();
    end
  end
  task automatic results();
    if (error_cnt == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask : tick
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {24'h0, d}, r, e);
  endtask : wr
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x, "read data");
    chk(32'(e), 32'(xe), "slave error");
  endtask : rd_chk
  task automatic pulse(input bit wake);
    @(posedge pclk);
    if (wake)
      wake_req <= 1'b1;
    else
      sleep_req <= 1'b1;
    @(posedge pclk);
    wake_req <= 1'b0;
    sleep_req <= 1'b0;
  endtask : pulse
  task automatic wait_core(output int m);
    m = 0;
    while (core_reset_n !== 1'b1 && m < 100) begin
      @(posedge pclk);
      #1;
      m++;
    end
  endtask : wait_core
  task automatic t_regs();
    rd_chk(OFS_SLEEP_CTRL, 32'h0, 1'b0);
    rd_chk(OFS_CLOCK_GATE, 32'h0, 1'b0);
    rd_chk(12'h0fc, 32'h0, 1'b1);
    rd_chk(OFS_FUSE_STAT, {26'h0, suf}, 1'b0);
  endtask : t_regs
  task automatic t_gate();
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CLOCK_GATE, 8'hf0 | (8'h01 << i));
      tick(2);
      chk(32'(gate_off), 32'h1 << i, "gate outputs");
      rd_chk(OFS_CLOCK_GATE, 32'h1 << i, 1'b0);
    end
    wr(OFS_CLOCK_GATE, 8'h00);
    tick(2);
    chk(32'(gate_off), 32'h0, "gate released");
  endtask : t_gate
  task automatic t_sleep();
    logic [4:0] ex[4] = '{5'h0b, 5'h03, 5'h00, 5'h1f};
    for (int c = 0; c < 4; c++) begin
      wr(OFS_SLEEP_CTRL, 8'h20 | 8'(c << 3));
      pulse(1'b0);
      tick(2);
      chk(32'(sleeping), 32'(c != 3), "sleep entry");
      chk(32'(clk_en), 32'(ex[c]), "sleep clocks");
      pulse(1'b1);
      tick(3);
      chk(32'(clk_en), 32'h1f, "clocks after wake");
      wr(OFS_SLEEP_CTRL, 8'h00);
    end
    wr(OFS_SLEEP_CTRL, 8'h10);
    pulse(1'b0);
    tick(2);
    chk(32'(sleeping), 32'h0, "sleep unarmed");
  endtask : t_sleep
  task automatic t_bandgap();
    for (int i = 0; i < 8; i++) begin
      @(posedge pclk);
      {brownout_level_fuse, comparator_bandgap_select, converter_enable} <= 3'(i);
      tick(2);
      chk(32'(bandgap_enable), 32'(i != 0), "bandgap");
    end
  endtask : t_bandgap
  task automatic t_bod();
    wr(OFS_SLEEP_CTRL, 8'hb4);
    wr(OFS_SLEEP_CTRL, 8'hb0);
    @(posedge pclk);
    pulse(1'b0);
    tick(1);
    chk(32'(brownout_detector_on), 32'h0, "detector off in sleep");
    pulse(1'b1);
    tick(3);
    chk(32'(brownout_detector_on), 32'h1, "detector back");
    rd_chk(OFS_SLEEP_CTRL, 32'h30, 1'b0);
    wr(OFS_SLEEP_CTRL, 8'hb0);
    pulse(1'b0);
    tick(2);
    chk(32'(brownout_detector_on), 32'h1, "no unlock");
    pulse(1'b1);
    wr(OFS_SLEEP_CTRL, 8'h00);
  endtask : t_bod
  task automatic t_resets();
    @(posedge pclk) power_on_low <= 1'b1;
    #1;
    chk(32'({ports_reset_n, core_reset_n}), 32'h0, "supply drop");
    @(posedge pclk) power_on_low <= 1'b0;
    wait_core(n);
    chk(n, STRETCH, "stretch length");
    @(posedge pclk) brownout_low <= 1'b1;
    suf <= 6'h05;
    #1;
    chk(32'({ports_reset_n, core_reset_n}), 32'h0, "brownout");
    @(posedge pclk) brownout_low <= 1'b0;
    wait_core(n);
    chk(n, DLY + 5 + 1, "brownout stretch");
    @(posedge pclk) watchdog_enable <= 1'b1;
    watchdog_expire <= 1'b1;
    @(posedge pclk) watchdog_expire <= 1'b0;
    n = 0;
    repeat (6) begin
      @(posedge pclk);
      #1;
      n += int'(watchdog_reset === 1'b1);
    end
    chk(n, 1, "watchdog pulse");
    chk(32'(core_reset_n), 32'h0, "watchdog reset");
    wait_core(n);
    chk(32'(core_reset_n), 32'h1, "watchdog restart");
    @(posedge pclk) reset_pin_enable <= 1'b1;
    pin_low_req <= 1'b1;
    tick(6);
    chk(32'({ports_reset_n, core_reset_n}), 32'h0, "pin reset");
    @(posedge pclk) pin_low_req <= 1'b0;
    wait_core(n);
    chk(32'(core_reset_n), 32'h1, "pin restart");
    @(posedge pclk) {reset_pin_enable, watchdog_enable, brownout_level_fuse} <= 3'b000;
    @(posedge pclk) {pin_low_req, watchdog_expire, brownout_low} <= 3'b111;
    tick(6);
    chk(32'(core_reset_n), 32'h1, "disabled sources");
    @(posedge pclk) {pin_low_req, watchdog_expire, brownout_low} <= 3'b000;
  endtask : t_resets
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    power_on_low <= 1'b0;
    wait_core(n);
    chk(n, STRETCH, "power-on stretch");
    t_regs();
    t_gate();
    t_sleep();
    t_bandgap();
    t_bod();
    t_resets();
    results();
  end
endmodule : srp_sleep_reset_test
